// >>> hdl/tfi_panel.sv
// Operator panel mode logic for one tape unit
`timescale 1ns/1ps
`default_nettype none
module tfi_panel (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Panel
    tfi_panel_if.unit  pnl
);
    logic hold_r;  // Operator-hold indicator
    logic pwr_r;   // Power-up indicator
    logic oth_r;   // Other switch accepted

    // Operator-hold mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 1'b0;
        end else if (pnl.rwi) begin
            hold_r <= 1'b1;
        end else if (!hold_r && pnl.sw_hold) begin
            hold_r <= 1'b1;
        end else if (hold_r && pwr_r && pnl.sw_marker) begin
            hold_r <= 1'b0;
        end
    end

    // Power state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_r <= 1'b0;
        end else if (hold_r && !pwr_r) begin
            if (pnl.sw_pwr_up) begin
                pwr_r <= 1'b1;
            end
        end else if (pnl.sw_pwr_down) begin
            pwr_r <= 1'b0;
        end else if (!hold_r && !pwr_r && pnl.sw_pwr_up) begin
            pwr_r <= 1'b0;
        end
    end

    // Other switches only when held and powered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oth_r <= 1'b0;
        end else begin
            oth_r <= pnl.sw_other && hold_r && pwr_r;
        end
    end

    assign pnl.hold_ind  = hold_r;
    assign pnl.pwr_ind   = pwr_r;
    assign pnl.other_eff = oth_r;
endmodule // tfi_panel
`default_nettype wire

// >>> hdl/tfi_panel_if.sv
// Interface carrying one tape unit's panel switches and indicators
`timescale 1ns/1ps
`default_nettype none
interface tfi_panel_if;
    logic sw_hold;       // Operator-hold switch pulse
    logic sw_pwr_down;   // Power-down switch pulse
    logic sw_pwr_up;     // Power-up switch pulse
    logic sw_marker;     // Tape-start-marker switch pulse
    logic sw_other;      // Any other panel switch pulse
    logic rwi;           // Rewind-with-interlock from control unit
    logic hold_ind;      // Operator-hold indicator
    logic pwr_ind;       // Power-up indicator
    logic other_eff;     // Other switch accepted
    modport ctl  (output sw_hold, sw_pwr_down, sw_pwr_up, sw_marker,
                  sw_other, rwi, input hold_ind, pwr_ind, other_eff);
    modport unit (input sw_hold, sw_pwr_down, sw_pwr_up, sw_marker,
                  sw_other, rwi, output hold_ind, pwr_ind, other_eff);
endinterface
`default_nettype wire

// >>> hdl/tfi_pkg.sv
// Package of constants and types for the tape function timing interlock
package tfi_pkg;
    // Clock rate and time base
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned US_PER_MS     = 1000;
    // Times in microseconds as printed in milliseconds
    localparam int unsigned READ_END_US   = 330;    // 0.33 ms
    localparam int unsigned WRITE_END_US  = 2740;   // 2.74 ms
    localparam int unsigned REVERSAL_US   = 12500;  // 12.5 ms
    // Cycle counts derived from the rate (cycles per microsecond round down)
    localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int unsigned READ_END_CYC  = READ_END_US * CYC_PER_US;
    localparam int unsigned WRITE_END_CYC = WRITE_END_US * CYC_PER_US;
    localparam int unsigned MS_TICK_CYC   = US_PER_MS * CYC_PER_US;
    localparam int unsigned REVERSAL_MS10 = REVERSAL_US / 100; // in 0.1 ms
    localparam int unsigned TICK_CYC      = CYC_PER_US * 100;  // 0.1 ms tick
    // Geometry
    localparam int unsigned NUM_UNITS     = 4;
    localparam int unsigned UNIT_W        = 2;
    localparam int unsigned LOGNUM_W      = 4;
    localparam int unsigned TIME_W        = 16;
    // APB register offsets
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT   = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK   = 8'h0C;
    localparam logic [7:0] REG_SLACK      = 8'h10;
    localparam logic [7:0] REG_LOGMAP     = 8'h14;
    // Reset values
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [2:0]  MASK_RST      = 3'h0;
    localparam logic [15:0] LOGMAP_RST    = 16'h3210;
    // Interrupt status bit positions
    localparam int unsigned IRQ_READY     = 0;
    localparam int unsigned IRQ_INTLK     = 1;
    localparam int unsigned IRQ_REVERSE   = 2;
    // Function codes
    typedef enum logic [2:0] {
        TFI_FN_NONE, TFI_FN_RDF, TFI_FN_RDB, TFI_FN_WR, TFI_FN_SKW,
        TFI_FN_RWI
    } tfi_fn_t;
endpackage

// >>> hdl/tfi_top.sv
// Tape function timing interlock: sequencing, timers, panels, APB
//
// Functional notes
// - Forward read: ready interrupt 0.33 ms after last frame
// - Backward read: ready 0.33 ms after first frame
// - Write or skip-write: ready 2.74 ms after
// - Measure slack from ready to read or data
// - Hold motion 12.5 ms on direction reversal
// - Each unit shows logical number 0 to 15
// - Number display lit only while powered up
// - Held unit gets no motion or conditioning
// - Function to held unit flags interlock status
// - Not held: only hold and power-down switches
// - Held, powered down: only power-up switch works
// - Held and powered: all switches effective
// - Rewind-with-interlock puts unit in hold
// - Marker switch releases operator hold
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tfi_top
    import tfi_pkg::*;
(
    // APB slave
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Channel side events (same clock domain)
    input  wire logic                  fn_valid,
    input  wire tfi_pkg::tfi_fn_t      fn_code,
    input  wire logic [1:0]            fn_unit,
    input  wire logic                  data_word,
    input  wire logic                  last_frame,
    // Panel switches per unit (asynchronous pins)
    input  wire logic [3:0]            sw_hold,
    input  wire logic [3:0]            sw_pwr_down,
    input  wire logic [3:0]            sw_pwr_up,
    input  wire logic [3:0]            sw_marker,
    input  wire logic [3:0]            sw_other,
    // Unit drive and display
    output logic [3:0]                 motion_fwd,
    output logic [3:0]                 motion_bwd,
    output logic [3:0]                 cond_en,
    output logic [3:0]                 hold_ind,
    output logic [15:0]                lognum_disp,
    output logic [3:0]                 lognum_on,
    output logic [3:0]                 other_eff,
    // Interrupt
    output logic                       status_ready_interrupt,
    output logic                       irq
);
    typedef enum {TFI_IDLE, TFI_WAIT_REV, TFI_MOVE, TFI_END} tfi_st_t;

    tfi_st_t            st_r;        // Sequencer state
    tfi_fn_t            fn_r;        // Current function
    logic [1:0]         unit_r;      // Current unit
    logic [31:0]        cnt_r;       // End timer
    logic [15:0]        tick_cnt_r;  // 0.1 ms divider
    logic               tick;        // 0.1 ms enable
    logic [3:0]         lastdir_r;   // 1 = last motion backward
    logic [TIME_W-1:0]  stop_t_r [NUM_UNITS]; // Time since stop
    logic [TIME_W-1:0]  slack_r;     // Ready-to-next in 0.1 ms
    logic               slack_run_r; // Slack counter active
    logic [2:0]         ist_r;       // Interrupt status
    logic [2:0]         imask_r;     // Interrupt mask
    logic [15:0]        logmap_r;    // Physical to logical map
    logic               ctrl_en_r;   // Sequencer enable
    logic               intlk_r;     // Interlock in last status
    logic [2:0]         ev;          // Event pulses
    logic [3:0]         hold_w, pwr_w, oth_w;
    logic               wr_en, rd_en;

    // Decode direction of a function
    function automatic logic fn_bwd(input tfi_fn_t f);
        return (f == TFI_FN_RDB);
    endfunction

    // Decode whether a function moves tape
    function automatic logic fn_moves(input tfi_fn_t f);
        return (f == TFI_FN_RDF) || (f == TFI_FN_RDB) ||
               (f == TFI_FN_WR) || (f == TFI_FN_SKW);
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // Time base divider, 0.1 ms enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 16'h0000;
        end else if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
            tick_cnt_r <= 16'h0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
        end
    end
    assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

    // Panels with synchronised switches
    generate
        for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
            tfi_panel_if pif ();
            logic [4:0] sync1_r; // Sync stage 1, read only by stage 2
            logic [4:0] sync2_r; // Sync stage 2
            logic [4:0] hist_r;  // Edge history
            // Two-flop sync then edge detect on second stage
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_r <= 5'h00;
                    sync2_r <= 5'h00;
                    hist_r  <= 5'h00;
                end else begin
                    sync1_r <= {sw_other[u], sw_marker[u], sw_pwr_up[u],
                                sw_pwr_down[u], sw_hold[u]};
                    sync2_r <= sync1_r;
                    hist_r  <= sync2_r;
                end
            end
            assign pif.sw_hold     = sync2_r[0] && !hist_r[0];
            assign pif.sw_pwr_down = sync2_r[1] && !hist_r[1];
            assign pif.sw_pwr_up   = sync2_r[2] && !hist_r[2];
            assign pif.sw_marker   = sync2_r[3] && !hist_r[3];
            assign pif.sw_other    = sync2_r[4] && !hist_r[4];
            assign pif.rwi = fn_valid && (fn_code == TFI_FN_RWI) &&
                             (fn_unit == u) && !hold_w[u];
            assign hold_w[u] = pif.hold_ind;
            assign pwr_w[u]  = pif.pwr_ind;
            assign oth_w[u]  = pif.other_eff;
            tfi_panel u_panel (
                .pclk    (pclk),
                .presetn (presetn),
                .pnl     (pif)
            );
            // Time since last stop, saturating, in 0.1 ms
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stop_t_r[u] <= 16'hFFFF;
                end else if (st_r == TFI_MOVE && unit_r == u) begin
                    stop_t_r[u] <= 16'h0000;
                end else if (tick && stop_t_r[u] != 16'hFFFF) begin
                    stop_t_r[u] <= stop_t_r[u] + 16'h0001;
                end
            end
        end
    endgenerate

    // Function sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= TFI_IDLE;
            fn_r   <= TFI_FN_NONE;
            unit_r <= 2'h0;
            cnt_r  <= 32'h0;
        end else begin
            case (st_r)
                TFI_IDLE: begin
                    if (fn_valid && ctrl_en_r && fn_moves(fn_code) &&
                        !hold_w[fn_unit]) begin
                        fn_r   <= fn_code;
                        unit_r <= fn_unit;
                        st_r   <= TFI_WAIT_REV;
                    end
                end
                TFI_WAIT_REV: begin
                    if (lastdir_r[unit_r] == fn_bwd(fn_r) ||
                        stop_t_r[unit_r] >= 16'(REVERSAL_MS10)) begin
                        st_r <= TFI_MOVE;
                    end
                end
                TFI_MOVE: begin
                    if (last_frame) begin
                        cnt_r <= (fn_r == TFI_FN_WR || fn_r == TFI_FN_SKW)
                            ? WRITE_END_CYC - 1
                            : READ_END_CYC - 1;
                        st_r  <= TFI_END;
                    end
                end
                TFI_END: begin
                    if (cnt_r == 32'h0) begin
                        st_r <= TFI_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                default: st_r <= TFI_IDLE;
            endcase
        end
    end

    // Last motion direction per unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lastdir_r <= 4'h0;
        end else if (st_r == TFI_MOVE) begin
            lastdir_r[unit_r] <= fn_bwd(fn_r);
        end
    end

    // Event pulses
    assign ev[IRQ_READY]   = (st_r == TFI_END) && (cnt_r == 32'h0);
    assign ev[IRQ_INTLK]   = fn_valid && hold_w[fn_unit];
    assign ev[IRQ_REVERSE] = (st_r == TFI_IDLE) && fn_valid &&
                             ctrl_en_r && fn_moves(fn_code) &&
                             !hold_w[fn_unit] &&
                             lastdir_r[fn_unit] != fn_bwd(fn_code) &&
                             stop_t_r[fn_unit] < 16'(REVERSAL_MS10);

    // Interlock flag for the returned status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            intlk_r <= 1'b0;
        end else if (fn_valid) begin
            intlk_r <= hold_w[fn_unit];
        end
    end

    // Slack measurement from ready to next read or data word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slack_r     <= 16'h0000;
            slack_run_r <= 1'b0;
        end else if (ev[IRQ_READY]) begin
            slack_r     <= 16'h0000;
            slack_run_r <= 1'b1;
        end else if (slack_run_r && (data_word || (fn_valid &&
                     (fn_code == TFI_FN_RDF || fn_code == TFI_FN_RDB)))) begin
            slack_run_r <= 1'b0;
        end else if (slack_run_r && tick && slack_r != 16'hFFFF) begin
            slack_r <= slack_r + 16'h0001;
        end
    end

    // Interrupt status, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_r <= 3'h0;
        end else if (wr_en && paddr == REG_IRQ_STAT) begin
            ist_r <= (ist_r & ~pwdata[2:0]) | ev;
        end else begin
            ist_r <= ist_r | ev;
        end
    end

    // Writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_r   <= MASK_RST;
            logmap_r  <= LOGMAP_RST;
            ctrl_en_r <= CTRL_RST[0];
        end else if (wr_en) begin
            case (paddr)
                REG_CTRL:     ctrl_en_r <= pwdata[0];
                REG_IRQ_MASK: imask_r   <= pwdata[2:0];
                REG_LOGMAP:   logmap_r  <= pwdata[15:0];
                default:      ;
            endcase
        end
    end

    // APB read data, no wait state; reads above REG_LOGMAP return zero with error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > REG_LOGMAP;
            if (rd_en) begin
                case (paddr)
                    REG_CTRL:     prdata <= {31'h0, ctrl_en_r};
                    REG_STATUS:   prdata <= {20'h0, pwr_w, hold_w,
                                             intlk_r, 1'b0,
                                             st_r == TFI_IDLE,
                                             st_r == TFI_WAIT_REV};
                    REG_IRQ_STAT: prdata <= {29'h0, ist_r};
                    REG_IRQ_MASK: prdata <= {29'h0, imask_r};
                    REG_SLACK:    prdata <= {16'h0, slack_r};
                    REG_LOGMAP:   prdata <= {16'h0, logmap_r};
                    default:      prdata <= 32'h0;
                endcase
            end
        end
    end

    // Unit drive, display and interrupt outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motion_fwd             <= 4'h0;
            motion_bwd             <= 4'h0;
            cond_en                <= 4'h0;
            hold_ind               <= 4'h0;
            lognum_disp            <= 16'h0;
            lognum_on              <= 4'h0;
            other_eff              <= 4'h0;
            status_ready_interrupt <= 1'b0;
            irq                    <= 1'b0;
        end else begin
            for (int u = 0; u < NUM_UNITS; u++) begin
                motion_fwd[u] <= st_r == TFI_MOVE && unit_r == u &&
                                 !fn_bwd(fn_r) && !hold_w[u];
                motion_bwd[u] <= st_r == TFI_MOVE && unit_r == u &&
                                 fn_bwd(fn_r) && !hold_w[u];
                cond_en[u]    <= st_r != TFI_IDLE && unit_r == u &&
                                 !hold_w[u];
                lognum_on[u]  <= pwr_w[u];
                lognum_disp[u*4 +: 4] <= pwr_w[u] ?
                    logmap_r[u*4 +: 4] : 4'h0;
            end
            hold_ind               <= hold_w;
            other_eff              <= oth_w;
            status_ready_interrupt <= ev[IRQ_READY];
            irq                    <= |(ist_r & imask_r);
        end
    end
endmodule // tfi_top
`default_nettype wire

// >>> testbench/tb_tfi_top.sv
// Self-checking testbench for the tape function timing interlock
`timescale 1ns/1ps
`default_nettype none
module tb_tfi_top;
    import tfi_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        fn_valid, data_word, last_frame, sri, irq, e;
    tfi_fn_t     fn_code;
    logic [1:0]  fn_unit;
    logic [3:0]  sw [5];
    logic [3:0]  mfwd, mbwd, cond_en, hold_ind, lon, oeff, eff_seen;
    logic [15:0] ldisp;
    int          miscompares, num_checks;
    always #20 pclk = ~pclk;
    // Gather accepted other-switch pulses
    always @(posedge pclk) eff_seen <= eff_seen | oeff;
    tfi_chan_model chan_u (.pclk(pclk), .fn_valid(fn_valid),
        .fn_code(fn_code), .fn_unit(fn_unit), .data_word(data_word),
        .last_frame(last_frame));
    tfi_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fn_valid(fn_valid), .fn_code(fn_code), .fn_unit(fn_unit),
        .data_word(data_word), .last_frame(last_frame), .sw_hold(sw[0]),
        .sw_pwr_down(sw[1]), .sw_pwr_up(sw[2]), .sw_marker(sw[3]),
        .sw_other(sw[4]), .motion_fwd(mfwd), .motion_bwd(mbwd),
        .cond_en(cond_en), .hold_ind(hold_ind), .lognum_disp(ldisp),
        .lognum_on(lon), .other_eff(oeff), .status_ready_interrupt(sri),
        .irq(irq));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin miscompares++; complete_run(); end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Count cycles from last frame to ready interrupt
    task automatic wait_sri(input int lo);
        int n;
        n = 0;
        do begin @(posedge pclk); n++; end while (sri !== 1'b1 && n < lo + 9);
        chk(32'(n >= lo && n <= lo + 3), 32'h1);
        if (n >= lo + 9) complete_run();
    endtask
    task automatic press(input int k, input int u);
        @(posedge pclk);
        sw[k][u] <= 1'b1;
        repeat (6) @(posedge pclk);
        sw[k][u] <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic t_regs();
        apb(1'b0, REG_CTRL, 32'h0); chk(r, CTRL_RST);
        apb(1'b0, REG_IRQ_MASK, 32'h0); chk(r, 32'(MASK_RST));
        apb(1'b0, REG_LOGMAP, 32'h0); chk(r, 32'(LOGMAP_RST));
        apb(1'b0, 8'h18, 32'h0); chk(r, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, REG_CTRL, 32'h1);
    endtask
    task automatic t_reads();
        chan_u.issue(TFI_FN_RDF, 2'h0);
        repeat (3) @(posedge pclk);
        chk(32'(mfwd[0]), 32'h1);
        chan_u.pulse(1'b1);
        wait_sri(READ_END_CYC);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        apb(1'b0, REG_IRQ_STAT, 32'h0); chk(r, 32'h1);
        apb(1'b1, REG_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1);
        apb(1'b1, REG_IRQ_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        apb(1'b1, REG_IRQ_MASK, 32'h0);
        repeat (2600) @(posedge pclk);
        chan_u.issue(TFI_FN_RDF, 2'h0);
        apb(1'b0, REG_SLACK, 32'h0); chk(32'(r == 1 || r == 2), 32'h1);
        chan_u.pulse(1'b1);
        wait_sri(READ_END_CYC);
        chan_u.issue(TFI_FN_RDB, 2'h1);
        repeat (3) @(posedge pclk);
        chk(32'(mbwd[1]), 32'h1);
        chan_u.pulse(1'b1);
        wait_sri(READ_END_CYC);
        chan_u.issue(TFI_FN_WR, 2'h2);
        chan_u.pulse(1'b0);
        chan_u.pulse(1'b1);
        wait_sri(WRITE_END_CYC);
    endtask
    task automatic t_hold();
        chan_u.issue(TFI_FN_RWI, 2'h3);
        repeat (10) @(posedge pclk);
        chk(32'(hold_ind[3]), 32'h1);
        apb(1'b1, REG_IRQ_STAT, 32'h7);
        chan_u.issue(TFI_FN_RDF, 2'h3);
        repeat (10) @(posedge pclk);
        chk(32'(mfwd[3] | cond_en[3]), 32'h0);
        apb(1'b0, REG_IRQ_STAT, 32'h0); chk(32'(r[IRQ_INTLK]), 32'h1);
        apb(1'b0, REG_STATUS, 32'h0); chk(32'(r[11:0]), 32'h08A);
    endtask
    // Reversal on a recently moved unit must wait
    task automatic t_rev();
        chan_u.issue(TFI_FN_RDB, 2'h0);
        repeat (10) @(posedge pclk);
        chk(32'(mbwd[0]), 32'h0);
        apb(1'b0, REG_STATUS, 32'h0); chk(32'(r[1:0]), 32'h1);
        apb(1'b0, REG_IRQ_STAT, 32'h0); chk(32'(r[IRQ_REVERSE]), 32'h1);
    endtask
    task automatic t_panel();
        @(negedge pclk) eff_seen = 4'h0;
        press(4, 3); chk(32'(eff_seen), 32'h0);
        press(2, 3); chk({lon[3], ldisp[15:12]}, 32'h13);
        press(4, 3); chk(32'(eff_seen[3]), 32'h1);
        press(3, 3); chk(32'(hold_ind[3]), 32'h0);
        @(negedge pclk) eff_seen = 4'h0;
        press(4, 3); chk(32'(eff_seen), 32'h0);
        press(1, 3); chk({lon[3], ldisp}, 32'h0);
        press(0, 3); chk(32'(hold_ind[3]), 32'h1);
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        foreach (sw[i]) sw[i] = 4'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_reads();
        t_hold();
        t_panel();
        t_rev();
        complete_run();
    end
endmodule // tb_tfi_top
`default_nettype wire

// >>> testbench/tfi_chan_model.sv
// Channel model issuing function words and frame events
`timescale 1ns/1ps
`default_nettype none
module tfi_chan_model (
    // Clock
    input  wire logic            pclk,
    // Function and frame events
    output var logic             fn_valid,
    output var tfi_pkg::tfi_fn_t fn_code,
    output var logic [1:0]       fn_unit,
    output var logic             data_word,
    output var logic             last_frame
);
    import tfi_pkg::*;
    tfi_fn_t last_fn [4]; // Last function per unit
    // Idle levels at time zero
    initial begin
        fn_valid = 1'b0;
        fn_code = TFI_FN_NONE;
        fn_unit = 2'h0;
        data_word = 1'b0;
        last_frame = 1'b0;
        foreach (last_fn[i]) last_fn[i] = TFI_FN_NONE;
    end
    // One-cycle function word; a forward read after a write on the same unit is skipped
    task automatic issue(input tfi_fn_t c, input logic [1:0] u);
        if (c == TFI_FN_RDF && last_fn[u] == TFI_FN_WR) return;
        last_fn[u] = c;
        @(posedge pclk);
        fn_valid <= 1'b1;
        fn_code <= c;
        fn_unit <= u;
        @(posedge pclk);
        fn_valid <= 1'b0;
        fn_code <= TFI_FN_NONE;
        fn_unit <= ~u;
    endtask
    // One-cycle pulse of data word or last frame
    task automatic pulse(input bit last);
        @(posedge pclk);
        if (last) last_frame <= 1'b1;
        else data_word <= 1'b1;
        @(posedge pclk);
        last_frame <= 1'b0;
        data_word <= 1'b0;
    endtask
endmodule // tfi_chan_model
`default_nettype wire

// >>> testbench/tfi_sva.sv
// Port checker for the tape function timing interlock
`timescale 1ns/1ps
`default_nettype none
module tfi_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Unit side
    input wire logic [3:0]  motion_fwd,
    input wire logic [3:0]  motion_bwd,
    input wire logic [3:0]  cond_en,
    input wire logic [3:0]  hold_ind,
    input wire logic [15:0] lognum_disp,
    input wire logic [3:0]  lognum_on,
    input wire logic [3:0]  other_eff,
    input wire logic        status_ready_interrupt
);
    logic [3:0] lit; // Display nibble nonzero, per unit
    // Collapse each display nibble to a lit flag
    always_comb begin
        for (int i = 0; i < 4; i++) lit[i] = |lognum_disp[4*i +: 4];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence answer_s; pready ##1 !pready; endsequence
    pready_answer_a: assert property (setup_s |=> answer_s)
        else $error("pready not a pulse after setup");
    pready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    slverr_map_a: assert property (pslverr |-> pready && paddr > 8'h14)
        else $error("pslverr on mapped address");
    slverr_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    ready_pulse_a: assert property (status_ready_interrupt |=> !status_ready_interrupt)
        else $error("ready interrupt longer than one cycle");
    held_quiet_a: assert property ((hold_ind & (motion_fwd | motion_bwd | cond_en)) == 4'h0)
        else $error("held unit driven");
    disp_dark_a: assert property ((lit & ~lognum_on) == 4'h0)
        else $error("display lit while unpowered");
    eff_mode_a: assert property ((other_eff & ~(hold_ind & lognum_on)) == 4'h0)
        else $error("other switch accepted in wrong mode");
    dir_excl_a: assert property ((motion_fwd & motion_bwd) == 4'h0)
        else $error("both directions driven");
endmodule // tfi_sva
bind tfi_top tfi_sva sva_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motion_fwd(motion_fwd),
    .motion_bwd(motion_bwd), .cond_en(cond_en), .hold_ind(hold_ind),
    .lognum_disp(lognum_disp), .lognum_on(lognum_on),
    .other_eff(other_eff), .status_ready_interrupt(status_ready_interrupt));
`default_nettype wire
